// File: rtl/ipdc_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "ipdc_consts.vh"
module ipdc_ctrl (
   input wire ref_clk,
   input wire nrst,
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   output wire sfr_hit,
   input wire insn_done,
   input wire irq_pending,
   input wire rst_pin,
   input wire ext_irq0_in_n,
   input wire ext_irq1_in_n,
   input wire [1:0] ext_irq_wake_en,
   input wire [3:0] key_wake_inputs,
   input wire [3:0] key_wake_en,
   input wire key_wake_level_high,
   input wire boot_jump_fuse,
   output wire cpu_clk_en,
   output wire per_clk_en,
   output wire osc_en,
   output wire ram_access_block,
   output reg core_reset,
   output reg resume_pulse,
   output reg boot_map_enable,
   output wire [3:0] power_config_reg
);
   ////////////////////////////////////////////////////////////////////////
   // Decode and raw wake detection

   function pwrcfg_sel;
      input [7:0] addr;
      begin
         pwrcfg_sel = (addr == `IPDC_PWRCFG_ADDR);
      end
   endfunction

   wire wr_hit;
   wire rd_hit;
   wire [1:0] int_raw;
   wire [3:0] key_match;
   wire key_raw;
   wire int_raw_any;
   wire wake_raw;

   assign wr_hit = sfr_wr && pwrcfg_sel(sfr_addr);
   assign rd_hit = sfr_rd && pwrcfg_sel(sfr_addr);
   assign sfr_hit = pwrcfg_sel(sfr_addr);

   // Pins active low; enables gate each one
   assign int_raw = ~{ext_irq1_in_n, ext_irq0_in_n} & ext_irq_wake_en; // R9
   assign key_match = key_wake_level_high ? key_wake_inputs
                                          : ~key_wake_inputs; // R11
   assign key_raw = |(key_match & key_wake_en); // R9
   assign int_raw_any = |int_raw;
   // Purely combinational so it works while the oscillator is stopped
   assign wake_raw = int_raw_any | key_raw; // R18

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   wire [3:0] pin_sync;
   wire int_s;
   wire key_s;
   wire rst_s;

   ipdc_sync2 #(
      .W(4)
   ) u_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .async_in({rst_pin, key_raw, int_raw}),
      .sync_out(pin_sync)
   );

   assign int_s = pin_sync[0] | pin_sync[1]; // R18
   assign key_s = pin_sync[2]; // R18
   assign rst_s = pin_sync[3];

   ////////////////////////////////////////////////////////////////////////
   // Power configuration register

   reg idle_request_q;
   reg powerdown_request_q;
   reg user_flag_0_q;
   reg user_flag_1_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg clr_modes;

   // Mode bits also clear straight from the reset pin, with no clock
   always @(posedge ref_clk or negedge nrst or posedge rst_pin)
   begin
      if (!nrst)
      begin
         idle_request_q <= 1'b0; // R16
         powerdown_request_q <= 1'b0; // R16
      end
      else if (rst_pin)
      begin
         idle_request_q <= 1'b0; // R5
         powerdown_request_q <= 1'b0; // R13
      end
      else if (clr_modes)
      begin
         idle_request_q <= 1'b0; // R4
         powerdown_request_q <= 1'b0; // R3
      end
      else if (wr_hit)
      begin
         idle_request_q <= sfr_wdata[`IPDC_BIT_IDLE];
         powerdown_request_q <= sfr_wdata[`IPDC_BIT_PWRDN];
      end
   end

   // Flags survive interrupt wakes; only the internal reset clears them
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         user_flag_0_q <= 1'b0; // R16
         user_flag_1_q <= 1'b0; // R16
      end
      else if (core_reset)
      begin
         user_flag_0_q <= 1'b0; // R14
         user_flag_1_q <= 1'b0; // R14
      end
      else if (wr_hit)
      begin
         user_flag_0_q <= sfr_wdata[`IPDC_BIT_FLAG0]; // R15
         user_flag_1_q <= sfr_wdata[`IPDC_BIT_FLAG1]; // R15
      end
   end

   assign power_config_reg = {user_flag_1_q, user_flag_0_q,
                              powerdown_request_q, idle_request_q};

   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sfr_rdata <= 8'h00;
      end
      else if (rd_hit)
      begin
         sfr_rdata <= {`IPDC_RSVD_READ, power_config_reg}; // R16
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wake and reset timer

   reg tmr_start;
   reg [`IPDC_TMR_W-1:0] tmr_len;
   wire tmr_done;

   ipdc_cycle_timer u_tmr (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .start(tmr_start),
      .length(tmr_len),
      .done(tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Mode sequencer

   reg rst_seen_q;
   wire enter_pwrdn;
   wire enter_idle;

   // A write in the completing instruction counts for entry
   assign enter_pwrdn = insn_done &&
      (powerdown_request_q || (wr_hit && sfr_wdata[`IPDC_BIT_PWRDN])); // R8
   assign enter_idle = insn_done &&
      (idle_request_q || (wr_hit && sfr_wdata[`IPDC_BIT_IDLE])); // R1

   always @*
   begin
      state_d = state_q;
      clr_modes = 1'b0;
      tmr_start = 1'b0;
      tmr_len = `IPDC_KEY_WAKE_CYCLES;
      case (state_q)
         `IPDC_ST_RUN:
         begin
            if (enter_pwrdn)
               state_d = `IPDC_ST_PWRDN; // R3
            else if (enter_idle)
               state_d = `IPDC_ST_IDLE; // R1
         end
         `IPDC_ST_IDLE:
         begin
            if (rst_s)
            begin
               state_d = `IPDC_ST_RSTW; // R5
            end
            else if (irq_pending)
            begin
               clr_modes = 1'b1; // R4
               state_d = `IPDC_ST_RUN; // R4
            end
         end
         `IPDC_ST_PWRDN:
         begin
            if (rst_s)
            begin
               state_d = `IPDC_ST_RSTW; // R13
            end
            else if (int_s)
            begin
               clr_modes = 1'b1; // R9
               state_d = `IPDC_ST_WINT; // R10
            end
            else if (key_s)
            begin
               clr_modes = 1'b1; // R9
               tmr_start = 1'b1; // R10
               state_d = `IPDC_ST_WKEY; // R10
            end
         end
         `IPDC_ST_WINT:
         begin
            if (rst_s)
               state_d = `IPDC_ST_RSTW;
            else if (!int_s)
               state_d = `IPDC_ST_RUN; // R10
         end
         `IPDC_ST_WKEY:
         begin
            if (rst_s)
               state_d = `IPDC_ST_RSTW;
            else if (tmr_done)
               state_d = `IPDC_ST_RUN; // R10
         end
         `IPDC_ST_RSTW:
         begin
            if (!rst_s)
               state_d = `IPDC_ST_RUN;
         end
         default:
         begin
            state_d = `IPDC_ST_RUN;
         end
      endcase
      // Takeover delay restarts on each fresh reset pin edge
      if (rst_s && !rst_seen_q)
      begin
         tmr_start = 1'b1;
         tmr_len = `IPDC_RST_TAKEOVER_CYCLES;
      end
   end

   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= `IPDC_ST_RUN;
         rst_seen_q <= 1'b0;
         core_reset <= 1'b0;
         resume_pulse <= 1'b0;
      end
      else
      begin
         state_q <= core_reset ? `IPDC_ST_RUN : state_d;
         rst_seen_q <= rst_s;
         // Internal reset holds while the pin stays high
         if (!rst_s)
            core_reset <= 1'b0;
         else if (tmr_done && !core_reset)
            core_reset <= 1'b1; // R5
         resume_pulse <= (state_q != `IPDC_ST_RUN) &&
                         (state_d == `IPDC_ST_RUN); // R4
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock gating and RAM guard

   wire st_idle;
   wire st_pwrdn;
   wire st_wait;
   reg lowpow_q;

   assign st_idle = (state_q == `IPDC_ST_IDLE);
   assign st_pwrdn = (state_q == `IPDC_ST_PWRDN);
   assign st_wait = (state_q == `IPDC_ST_WINT) ||
                    (state_q == `IPDC_ST_WKEY);

   // Idle and power-down gating follows the mode bits, so the reset pin reopens those at once
   assign cpu_clk_en = !((st_idle && idle_request_q) ||
                         (st_pwrdn && powerdown_request_q) ||
                         st_wait); // R2 R7
   assign per_clk_en = !(st_pwrdn && powerdown_request_q); // R2 R7
   // Raw wake starts the oscillator before any clock edge exists
   assign osc_en = !(st_pwrdn && powerdown_request_q) || wake_raw ||
                   rst_pin; // R7 R18

   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         lowpow_q <= 1'b0;
      else if (core_reset)
         lowpow_q <= 1'b0;
      else if (st_idle || st_pwrdn)
         lowpow_q <= 1'b1;
      else if (state_q == `IPDC_ST_RUN)
         lowpow_q <= 1'b0;
   end

   // Port pins stay usable; only RAM is fenced during the reset gap
   assign ram_access_block = (lowpow_q || state_q == `IPDC_ST_RSTW) &&
                             !(idle_request_q || powerdown_request_q) &&
                             (rst_s || rst_pin); // R6

   ////////////////////////////////////////////////////////////////////////
   // Boot mapping

   reg boot_loaded_q;

   // Fuse is caught after the release, never under the async reset
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         boot_loaded_q <= 1'b0;
         boot_map_enable <= 1'b0;
      end
      else if (!boot_loaded_q || core_reset)
      begin
         boot_loaded_q <= 1'b1;
         boot_map_enable <= boot_jump_fuse; // R17
      end
   end

endmodule // ipdc_ctrl
`default_nettype wire

// File: rtl/ipdc_consts.vh
// Functional notes
// [R1] Idle starts when idle-setting instruction completes
// [R2] Idle stops CPU clock, peripherals keep running
// [R3] Both bits set: power-down only, no idle
// [R4] Enabled interrupt clears idle bit, restores CPU
// [R5] Reset pin clears idle bit asynchronously
// [R6] RAM blocked until internal reset takes over
// [R7] Power-down stops oscillator and all clocks
// [R8] Power-down starts after the setting instruction
// [R9] Either external pin or key wakes power-down
// [R10] Pin wake waits release; key wake 1024 clocks
// [R11] Key wake level polarity is selectable
// [R12] Software makes wake interrupt level, top priority
// [R13] Reset pin clears power-down bit asynchronously
// [R14] Interrupt exit keeps registers; reset clears them
// [R15] Two user flags at bits 3 and 2
// [R16] Low four bits reset to zero; upper read zero
// [R17] Boot map enable loaded from fuse at reset
// [R18] Wake detect works without clock, then synchronised
`ifndef IPDC_CONSTS_VH
`define IPDC_CONSTS_VH
`define IPDC_PWRCFG_ADDR 8'h87
`define IPDC_PWRCFG_RESET 4'h0
`define IPDC_BIT_IDLE 0
`define IPDC_BIT_PWRDN 1
`define IPDC_BIT_FLAG0 2
`define IPDC_BIT_FLAG1 3
`define IPDC_RSVD_READ 4'h0
`define IPDC_KEY_WAKE_CYCLES 11'h400
`define IPDC_RST_TAKEOVER_CYCLES 11'h018
`define IPDC_TMR_W 11
`define IPDC_ST_RUN 3'h0
`define IPDC_ST_IDLE 3'h1
`define IPDC_ST_PWRDN 3'h2
`define IPDC_ST_WINT 3'h3
`define IPDC_ST_WKEY 3'h4
`define IPDC_ST_RSTW 3'h5
`endif

// File: rtl/ipdc_sync2.v
`timescale 1ns/1ps
`default_nettype none
module ipdc_sync2 #(
   parameter W = 1
)(
   input wire ref_clk,
   input wire nrst,
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // First stage feeds only the second stage
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // ipdc_sync2
`default_nettype wire

// File: rtl/ipdc_cycle_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "ipdc_consts.vh"
module ipdc_cycle_timer (
   input wire ref_clk,
   input wire nrst,
   input wire start,
   input wire [`IPDC_TMR_W-1:0] length,
   output wire done
);
   reg [`IPDC_TMR_W-1:0] cnt_q;
   reg run_q;

   // Done is a one-cycle pulse: high once length cycles have passed since start
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_q <= {`IPDC_TMR_W{1'b0}};
         run_q <= 1'b0;
      end
      else if (start)
      begin
         cnt_q <= length - 1'b1;
         run_q <= 1'b1;
      end
      else if (run_q && cnt_q != {`IPDC_TMR_W{1'b0}})
      begin
         cnt_q <= cnt_q - 1'b1;
      end
      else
      begin
         run_q <= 1'b0;
      end
   end

   assign done = run_q && (cnt_q == {`IPDC_TMR_W{1'b0}});
endmodule // ipdc_cycle_timer
`default_nettype wire

// File: testbench/ipdc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ipdc_ctrl_sva (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_hit,
   input wire logic insn_done,
   input wire logic irq_pending,
   input wire logic rst_pin,
   input wire logic boot_jump_fuse,
   input wire logic cpu_clk_en,
   input wire logic per_clk_en,
   input wire logic ram_access_block,
   input wire logic core_reset,
   input wire logic resume_pulse,
   input wire logic boot_map_enable,
   input wire logic [3:0] power_config_reg
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   idle_entry_a: assert property (
      power_config_reg[1:0] == 2'b01 && insn_done && !irq_pending && !rst_pin
      |=> !cpu_clk_en && per_clk_en) else $error("idle entry wrong");
   pwrdn_entry_a: assert property (
      power_config_reg[1] && insn_done && !rst_pin
      |=> !cpu_clk_en && !per_clk_en) else $error("power-down entry wrong");
   pin_clear_a: assert property (
      rst_pin |-> power_config_reg[1:0] == 2'b00 && cpu_clk_en)
      else $error("reset pin did not clear mode");
   ram_block_a: assert property (
      rst_pin && !core_reset |-> ram_access_block)
      else $error("ram not blocked");
   takeover_a: assert property (
      $rose(core_reset) |-> $past(rst_pin, 20))
      else $error("internal reset too early");
   irq_exit_a: assert property (
      power_config_reg[1:0] == 2'b01 && !cpu_clk_en && irq_pending
      && !rst_pin |=> cpu_clk_en && !power_config_reg[0])
      else $error("idle exit wrong");
   resume_one_a: assert property (
      resume_pulse |-> cpu_clk_en && !$past(resume_pulse))
      else $error("resume pulse wrong");
   flag_write_a: assert property (
      sfr_wr && sfr_hit && !core_reset
      |=> power_config_reg[3:2] == $past(sfr_wdata[3:2]))
      else $error("flag write lost");
   read_back_a: assert property (
      sfr_rd && sfr_hit |=> sfr_rdata == {4'h0, $past(power_config_reg)})
      else $error("read data wrong");
   miss_ignored_a: assert property (
      sfr_wr && !sfr_hit && !core_reset |=> $stable(power_config_reg[3:2]))
      else $error("other address changed flags");
   boot_load_a: assert property (
      $past(nrst) |-> boot_map_enable == boot_jump_fuse)
      else $error("boot map not loaded");
endmodule // ipdc_ctrl_sva
bind ipdc_ctrl ipdc_ctrl_sva sva_i (.*);
`default_nettype wire

// File: testbench/ipdc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module ipdc_cpu_model (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic cpu_clk_en,
   input wire logic per_clk_en,
   input wire logic core_reset,
   input wire logic irq_req,
   output logic insn_done,
   output var logic irq_pending
);
   // Core retires one instruction in every cycle its clock runs outside core reset
   assign insn_done = cpu_clk_en & ~core_reset;
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         irq_pending <= 1'b0;
      else
         irq_pending <= irq_req & per_clk_en;
   end
endmodule // ipdc_cpu_model
`default_nettype wire

// File: testbench/idle_powerdown_controller_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
   begin \
      n_tests++; \
      if ((g) !== (e)) \
      begin \
         bad_count++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
      end \
   end
module idle_powerdown_controller_test;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] sfr_addr = 8'h87;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic rst_pin = 1'b0;
   logic [1:0] ext_n = 2'h3;
   logic [1:0] ext_irq_wake_en = 2'h3;
   logic [3:0] key_wake_inputs = 4'h0;
   logic [3:0] key_wake_en = 4'h2;
   logic key_wake_level_high = 1'b1;
   logic boot_jump_fuse = 1'b1;
   logic irq_req = 1'b0;
   wire ext_irq0_in_n = ext_n[0];
   wire ext_irq1_in_n = ext_n[1];
   wire [7:0] sfr_rdata;
   wire [3:0] power_config_reg;
   wire sfr_hit, insn_done, irq_pending, cpu_clk_en, per_clk_en, osc_en;
   wire ram_access_block, core_reset, resume_pulse, boot_map_enable;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int n;

   ipdc_ctrl dut (.*);
   ipdc_cpu_model cpu_i (.*);

   initial
   begin
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic finish_test;
      if (bad_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Hang guard: the whole run needs about 2300 cycles
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         bad_count++;
         finish_test;
      end
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] e);
      @(posedge ref_clk);
      sfr_addr <= 8'h87;
      sfr_rd <= 1'b1;
      @(posedge ref_clk);
      sfr_rd <= 1'b0;
      #1;
      `CHK(sfr_rdata, e)
   endtask

   // Waits on cpu clock (0), peripheral clock (1) or core reset (2)
   task automatic wt(input int s, input logic v, output int c);
      c = 0;
      #1;
      while (((s == 0) ? cpu_clk_en : (s == 1) ? per_clk_en : core_reset)
             !== v && c < 3000)
      begin
         @(posedge ref_clk);
         #1;
         c++;
      end
      if (c >= 3000)
         bad_count++;
   endtask

   initial
   begin
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rd(8'h00);
      `CHK(boot_map_enable, 1'b1)
      wr(8'h87, 8'hFC);
      wr(8'h86, 8'h00);
      rd(8'h0C);
      wr(8'h87, 8'h0D);
      wt(0, 1'b0, n);
      `CHK({per_clk_en, n < 4}, 2'b11)
      @(posedge ref_clk) irq_req <= 1'b1;
      wt(0, 1'b1, n);
      `CHK(power_config_reg, 4'hC)
      @(posedge ref_clk) irq_req <= 1'b0;
      // Both key polarities; the high-level pass also sets both mode bits
      for (int p = 0; p < 2; p++)
      begin
         @(posedge ref_clk);
         key_wake_level_high <= p[0];
         key_wake_inputs <= p[0] ? 4'h0 : 4'hF;
         wr(8'h87, p[0] ? 8'h03 : 8'h02);
         wt(1, 1'b0, n);
         `CHK({cpu_clk_en, osc_en}, 2'b00)
         repeat (20) @(posedge ref_clk);
         key_wake_inputs[1] <= p[0];
         #1;
         `CHK(osc_en, 1'b1)
         wt(1, 1'b1, n);
         wt(0, 1'b1, n);
         `CHK(n > 1021 && n < 1027, 1'b1)
         `CHK(power_config_reg[1:0], 2'b00)
         #16;
         `CHK(cpu_clk_en, 1'b1)
      end
      @(posedge ref_clk) key_wake_inputs <= 4'h0;
      for (int i = 0; i < 2; i++)
      begin
         wr(8'h87, 8'h02);
         wt(1, 1'b0, n);
         // Disabled keys at their active level must not wake the part
         @(posedge ref_clk) key_wake_inputs <= 4'hD;
         repeat (8) @(posedge ref_clk);
         #1;
         `CHK({per_clk_en, osc_en}, 2'b00)
         @(posedge ref_clk) ext_n[i] <= 1'b0;
         wt(1, 1'b1, n);
         repeat (40) @(posedge ref_clk);
         `CHK(cpu_clk_en, 1'b0)
         ext_n[i] <= 1'b1;
         wt(0, 1'b1, n);
         `CHK(n < 6, 1'b1)
      end
      for (int j = 1; j < 3; j++)
      begin
         wr(8'h87, 8'h0C | j[7:0]);
         wt(0, 1'b0, n);
         @(posedge ref_clk) rst_pin <= 1'b1;
         #1;
         `CHK(power_config_reg, 4'hC)
         `CHK({cpu_clk_en, per_clk_en, ram_access_block}, 3'h7)
         wt(2, 1'b1, n);
         `CHK(n > 20, 1'b1)
         @(posedge ref_clk) rst_pin <= 1'b0;
         wt(2, 1'b0, n);
         rd(8'h00);
      end
      finish_test;
   end
endmodule // idle_powerdown_controller_test
`default_nettype wire
